// [nomc_top.sv]
// operation control and mode definition registers behind axi4-lite
// assumes rst_b is the power-up reset and all inputs are synchronous to mclk
// except the status pins, synchronised here
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "nomc_regs.svh"
module nomc_top (
   // clock and power-up reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // device status pins
   input  wire logic        crystal_ok,
   input  wire logic        field_on_cmd,
   input  wire logic        active_tx_done,
   // control outputs to analog and protocol logic
   output logic             osc_reg_enable,
   output logic             ready_mode,
   output logic             rx_enable,
   output logic             rx_am_active,
   output logic             rx_pm_active,
   output logic             rx_auto_select,
   output logic             tx_enable,
   output logic             wake_up_mode,
   output nomc_pkg::nomc_fd_t field_detector_mode,
   output logic             low_power_nfc_mode,
   output logic             target_role,
   output nomc_pkg::nomc_mode_t protocol_mode,
   output logic             modulation_am,
   output logic [1:0]       auto_response_field,
   output logic             auto_response_start,
   output logic             brd_type_f,
   output logic             brd_type_a,
   output logic             use_passive_target_drive,
   // receive channel pick comes from another register
   input  wire logic        receive_channel_pick
);
   import nomc_pkg::*;

   // ======================================================================
   // synchronisers for pin inputs
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= {crystal_ok, field_on_cmd, active_tx_done};
         sync2_reg <= sync1_reg;
      end
   end
   wire osc_ok_s  = sync2_reg[2];
   wire fon_s     = sync2_reg[1];
   wire txdone_s  = sync2_reg[0];

   // edge detect on the synchronised events, so a long pulse acts once
   logic fon_d_reg;
   logic txdone_d_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fon_d_reg    <= 1'b0;
         txdone_d_reg <= 1'b0;
      end else begin
         fon_d_reg    <= fon_s;
         txdone_d_reg <= txdone_s;
      end
   end
   wire fon_evt    = fon_s & ~fon_d_reg;
   wire txdone_evt = txdone_s & ~txdone_d_reg;

   // ======================================================================
   // register storage
   logic [7:0] opctl_reg;
   logic [7:0] opctl_next;
   logic [7:0] modedef_reg;
   logic [7:0] modedef_next;

   // ======================================================================
   // axi write channel: address and data taken in either order
   logic       aw_held_reg;
   logic [7:0] aw_addr_reg;
   logic       w_held_reg;
   logic [7:0] w_data_reg;
   logic       w_strb0_reg;
   nomc_wst_t  wst_reg;
   logic       bvalid_reg;
   logic [1:0] bresp_reg;

   wire aw_take  = s_axi_awvalid & ~aw_held_reg & (wst_reg == NOMC_W_IDLE);
   wire w_take   = s_axi_wvalid & ~w_held_reg & (wst_reg == NOMC_W_IDLE);
   wire aw_have  = aw_held_reg | aw_take;
   wire w_have   = w_held_reg | w_take;
   wire [7:0] wa = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   wire [7:0] wd = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
   wire       ws = w_held_reg ? w_strb0_reg : s_axi_wstrb[0];
   wire do_write = aw_have & w_have & (wst_reg == NOMC_W_IDLE);
   wire hit_op   = (wa == 8'(`NOMC_ADDR_OPCTL));
   wire hit_md   = (wa == 8'(`NOMC_ADDR_MODEDEF));
   wire wr_op    = do_write & hit_op & ws;
   wire wr_md    = do_write & hit_md & ws & osc_ok_s;
   // refused mode write answers slverr
   wire [1:0] wresp = (hit_op | (hit_md & osc_ok_s)) ?
                      `NOMC_RESP_OKAY : `NOMC_RESP_SLVERR;

   // write handshake state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 8'h00;
         w_strb0_reg <= 1'b0;
         wst_reg     <= NOMC_W_IDLE;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
      end else begin
         case (wst_reg)
            NOMC_W_IDLE: begin
               if (do_write) begin
                  aw_held_reg <= 1'b0;
                  w_held_reg  <= 1'b0;
                  bvalid_reg  <= 1'b1;
                  bresp_reg   <= wresp;
                  wst_reg     <= NOMC_W_RESP;
               end else begin
                  if (aw_take) begin
                     aw_held_reg <= 1'b1;
                     aw_addr_reg <= s_axi_awaddr;
                  end
                  if (w_take) begin
                     w_held_reg  <= 1'b1;
                     w_data_reg  <= s_axi_wdata[7:0];
                     w_strb0_reg <= s_axi_wstrb[0];
                  end
               end
            end
            NOMC_W_RESP: begin
               if (s_axi_bready) begin
                  bvalid_reg <= 1'b0;
                  wst_reg    <= NOMC_W_IDLE;
               end
            end
            default: wst_reg <= NOMC_W_IDLE;
         endcase
      end
   end

   // ======================================================================
   // register next values
   always_comb begin
      opctl_next = opctl_reg;
      if (wr_op) begin
         opctl_next = wd;
      end
      // hardware updates of transmit enable; set wins over clear
      if (txdone_evt && (protocol_mode == NOMC_M_AP2P || protocol_mode == NOMC_M_TG_AP)) begin
         opctl_next[`NOMC_OP_TXEN] = 1'b0;
      end
      if (fon_evt) begin
         opctl_next[`NOMC_OP_TXEN] = 1'b1;
      end
   end
   assign modedef_next = wr_md ? wd : modedef_reg;

   // only rst_b, the power-up reset, loads the defaults
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         opctl_reg   <= `NOMC_OPCTL_RST;
         modedef_reg <= `NOMC_MODEDEF_RST;
      end else begin
         opctl_reg   <= opctl_next;
         modedef_reg <= modedef_next;
      end
   end

   // ======================================================================
   // axi read channel, one read at a time
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   wire ar_take  = s_axi_arvalid & ~rvalid_reg;
   wire rd_op    = (s_axi_araddr == 8'(`NOMC_ADDR_OPCTL));
   wire rd_md    = (s_axi_araddr == 8'(`NOMC_ADDR_MODEDEF));
   wire [7:0] rd_val = rd_op ? opctl_reg : (rd_md ? modedef_reg : 8'h00);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= 2'h0;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= {24'h00_0000, rd_val};
         rresp_reg  <= (rd_op | rd_md) ? `NOMC_RESP_OKAY : `NOMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ======================================================================
   // mode decode
   nomc_mode_t dec_mode;
   logic       dec_supported;
   logic       dec_brd_f;
   logic       dec_brd_a;
   nomc_decode u_decode (
      .role_target         (modedef_reg[`NOMC_MD_TARG]),
      .operation_mode_code (modedef_reg[`NOMC_MD_OM_HI:`NOMC_MD_OM_LO]),
      .mode                (dec_mode),
      .supported           (dec_supported),
      .brd_type_f          (dec_brd_f),
      .brd_type_a          (dec_brd_a)
   );

   // ======================================================================
   // control decode feeding the output flops
   wire en_b   = opctl_reg[`NOMC_OP_EN];
   wire rxen_b = opctl_reg[`NOMC_OP_RXEN];
   wire chn_b  = opctl_reg[`NOMC_OP_RXCHN];
   wire man_b  = opctl_reg[`NOMC_OP_RXMAN];
   wire txen_b = opctl_reg[`NOMC_OP_TXEN];
   wire [1:0] fd_b = opctl_reg[1:0];
   // receive needs a supported mode, otherwise both paths stay off
   wire rx_on  = rxen_b & dec_supported;
   wire tx_on  = txen_b & dec_supported;
   // single channel: pick 0 means am, 1 means pm
   wire am_on  = rx_on & (~chn_b | ~receive_channel_pick);
   wire pm_on  = rx_on & (~chn_b | receive_channel_pick);
   wire auto_s = rx_on & ~chn_b & ~man_b;
   wire lp_nfc = (fd_b != 2'h0) & (opctl_reg[7:2] == 6'h00);
   wire pt_drv = (dec_mode == NOMC_M_PT_A) | (dec_mode == NOMC_M_PT_F) |
                 (dec_mode == NOMC_M_BRD);
   wire [1:0] ar_b = modedef_reg[1:0];
   // reserved code 11 behaves as off
   wire ar_go  = (ar_b == 2'h1) | (ar_b == 2'h2);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         osc_reg_enable           <= 1'b0;
         ready_mode               <= 1'b0;
         rx_enable                <= 1'b0;
         rx_am_active             <= 1'b0;
         rx_pm_active             <= 1'b0;
         rx_auto_select           <= 1'b0;
         tx_enable                <= 1'b0;
         wake_up_mode             <= 1'b0;
         field_detector_mode      <= NOMC_FD_OFF;
         low_power_nfc_mode       <= 1'b0;
         target_role              <= 1'b0;
         protocol_mode            <= NOMC_M_NONE;
         modulation_am            <= 1'b0;
         auto_response_field      <= 2'h0;
         auto_response_start      <= 1'b0;
         brd_type_f               <= 1'b0;
         brd_type_a               <= 1'b0;
         use_passive_target_drive <= 1'b0;
      end else begin
         osc_reg_enable           <= en_b;
         ready_mode               <= en_b & osc_ok_s;
         rx_enable                <= rx_on;
         rx_am_active             <= am_on;
         rx_pm_active             <= pm_on;
         rx_auto_select           <= auto_s;
         tx_enable                <= tx_on;
         wake_up_mode             <= opctl_reg[`NOMC_OP_WU];
         field_detector_mode      <= nomc_fd_t'(fd_b);
         low_power_nfc_mode       <= lp_nfc;
         target_role              <= modedef_reg[`NOMC_MD_TARG];
         protocol_mode            <= dec_mode;
         modulation_am            <= modedef_reg[`NOMC_MD_AM];
         auto_response_field      <= ar_b;
         auto_response_start      <= ar_go;
         brd_type_f               <= dec_brd_f;
         brd_type_a               <= dec_brd_a;
         use_passive_target_drive <= pt_drv;
      end
   end

   // ======================================================================
   // axi outputs straight from flops, except the readies, which come combinationally from the take terms
   assign s_axi_awready = aw_take;
   assign s_axi_wready  = w_take;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ar_take;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
endmodule // nomc_top
`default_nettype wire

// [nomc_regs.svh]
// constants for the operation mode control register bank
// assumes an axi4-lite slave with 32-bit data, registers one per aligned word
//
// Operation
// - master enable bit 7 starts oscillator and regulators, ready mode
// - receive enable bit 6 turns receive on or off
// - bit 5 zero: both channels; one: single channel chosen by channel pick
// - with both channels, bit 4 picks automatic or manual channel selection
// - transmit enable bit 3; hardware sets on field-on, clears after active transmit
// - wake-up enable bit 2 puts device in wake-up mode
// - field detector field: off, collision threshold, peer threshold, automatic
// - operation control defaults load only at power-up
// - role bit 7 of mode register: initiator 0, target 1
// - mode code in bits 6..3, reset value 0001
// - modulation bit 2: on-off keying 0, amplitude modulation 1
// - auto response field: off, after any reception, after peer field-off, reserved
// - mode register writes only accepted while crystal stable flag is 1
// - initiator mode codes decode to seven protocols, others reserved
// - unsupported mode code disables transmit and receive
// - target codes 0001, 0100, 0111 valid; other top-bit-zero codes not allowed
// - target code with top bit set is bit rate detection with enables
// - passive target and detection modes drive field via drive resistance
`ifndef NOMC_REGS_SVH
`define NOMC_REGS_SVH

// ==========================================================================
// register offsets (byte addresses are four times the index)
`define NOMC_IDX_OPCTL      8'h02
`define NOMC_IDX_MODEDEF    8'h03
`define NOMC_ADDR_OPCTL     (`NOMC_IDX_OPCTL * 4)
`define NOMC_ADDR_MODEDEF   (`NOMC_IDX_MODEDEF * 4)

// ==========================================================================
// field positions
`define NOMC_OP_EN          7
`define NOMC_OP_RXEN        6
`define NOMC_OP_RXCHN       5
`define NOMC_OP_RXMAN       4
`define NOMC_OP_TXEN        3
`define NOMC_OP_WU          2
`define NOMC_MD_TARG        7
`define NOMC_MD_OM_HI       6
`define NOMC_MD_OM_LO       3
`define NOMC_MD_AM          2

// ==========================================================================
// reset values
`define NOMC_OPCTL_RST      8'h00
`define NOMC_MODEDEF_RST    8'h08

// ==========================================================================
// axi responses
`define NOMC_RESP_OKAY      2'h0
`define NOMC_RESP_SLVERR    2'h2

`endif

// [nomc_pkg.sv]
// types for the operation mode control register bank
// assumes nomc_regs.svh supplies the numeric constants
package nomc_pkg;
   // decoded protocol mode
   typedef enum logic [3:0] {
      NOMC_M_NONE   = 4'h0,
      NOMC_M_AP2P   = 4'h1,
      NOMC_M_TYPEA  = 4'h2,
      NOMC_M_TYPEB  = 4'h3,
      NOMC_M_TYPEF  = 4'h4,
      NOMC_M_T1T    = 4'h5,
      NOMC_M_SUBC   = 4'h6,
      NOMC_M_BPSK   = 4'h7,
      NOMC_M_PT_A   = 4'h8,
      NOMC_M_PT_F   = 4'h9,
      NOMC_M_TG_AP  = 4'hA,
      NOMC_M_BRD    = 4'hB
   } nomc_mode_t;

   // field detector setting
   typedef enum logic [1:0] {
      NOMC_FD_OFF  = 2'h0,
      NOMC_FD_CA   = 2'h1,
      NOMC_FD_PEER = 2'h2,
      NOMC_FD_AUTO = 2'h3
   } nomc_fd_t;

   // write handshake states
   typedef enum logic [1:0] {
      NOMC_W_IDLE = 2'b00,
      NOMC_W_RESP = 2'b01
   } nomc_wst_t;
endpackage

// [nomc_decode.sv]
// combinational decode of the mode definition register
// assumes register values from the same clock domain
`timescale 1ns/100ps
`default_nettype none
`include "nomc_regs.svh"
module nomc_decode (
   // register fields
   input  wire logic               role_target,
   input  wire logic [3:0]         operation_mode_code,
   // decoded results
   output nomc_pkg::nomc_mode_t    mode,
   output logic                    supported,
   output logic                    brd_type_f,
   output logic                    brd_type_a
);
   import nomc_pkg::*;

   // ======================================================================
   // role-dependent mode table
   always_comb begin
      mode = NOMC_M_NONE;
      if (!role_target) begin
         case (operation_mode_code)
            4'h0: mode = NOMC_M_AP2P;
            4'h1: mode = NOMC_M_TYPEA;
            4'h2: mode = NOMC_M_TYPEB;
            4'h3: mode = NOMC_M_TYPEF;
            4'h4: mode = NOMC_M_T1T;
            4'hE: mode = NOMC_M_SUBC;
            4'hF: mode = NOMC_M_BPSK;
            default: mode = NOMC_M_NONE;
         endcase
      end else if (operation_mode_code[3]) begin
         mode = NOMC_M_BRD;
      end else begin
         case (operation_mode_code)
            4'h1: mode = NOMC_M_PT_A;
            4'h4: mode = NOMC_M_PT_F;
            4'h7: mode = NOMC_M_TG_AP;
            default: mode = NOMC_M_NONE;
         endcase
      end
   end

   assign supported  = (mode != NOMC_M_NONE);
   // code bit 1 is reserved in detection mode
   assign brd_type_f = (mode == NOMC_M_BRD) & operation_mode_code[2];
   assign brd_type_a = (mode == NOMC_M_BRD) & operation_mode_code[0];
endmodule // nomc_decode
`default_nettype wire

// [nomc_checker.sv]
// nomc_checker: port-level assertions for the operation mode control bank
// assumes it is bound onto nomc_top and sees one clock domain, mclk
`timescale 1ns/100ps
`default_nettype none
module nomc_checker (
   // clock and power-up reset
   input wire logic                 mclk,
   input wire logic                 rst_b,
   // bus handshakes
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [1:0]           s_axi_bresp,
   // control outputs
   input wire logic                 osc_reg_enable,
   input wire logic                 ready_mode,
   input wire logic                 rx_enable,
   input wire logic                 rx_am_active,
   input wire logic                 rx_pm_active,
   input wire logic                 rx_auto_select,
   input wire logic                 tx_enable,
   input wire nomc_pkg::nomc_fd_t   field_detector_mode,
   input wire logic                 low_power_nfc_mode,
   input wire logic                 target_role,
   input wire nomc_pkg::nomc_mode_t protocol_mode,
   input wire logic [1:0]           auto_response_field,
   input wire logic                 auto_response_start,
   input wire logic                 brd_type_f,
   input wire logic                 brd_type_a,
   input wire logic                 use_passive_target_drive
);
   import nomc_pkg::*;
   // ==========================================================
   // all control outputs are registered from one state, so they must agree
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_READY: assert property (ready_mode |-> osc_reg_enable)
      else $error("ready without osc");
   AST_AUTOSEL: assert property (rx_auto_select |-> rx_am_active && rx_pm_active)
      else $error("auto select bad");
   AST_LOWPWR: assert property (low_power_nfc_mode |-> field_detector_mode != NOMC_FD_OFF
      && !osc_reg_enable && !rx_enable && !tx_enable)
      else $error("low power bad");
   AST_UNSUP: assert property (protocol_mode == NOMC_M_NONE |-> !rx_enable && !tx_enable)
      else $error("unsupported mode on");
   AST_ARSTART: assert property (auto_response_start == (auto_response_field inside {2'h1, 2'h2}))
      else $error("auto response bad");
   AST_PTDRV: assert property (use_passive_target_drive ==
      (protocol_mode inside {NOMC_M_PT_A, NOMC_M_PT_F, NOMC_M_BRD}))
      else $error("target drive bad");
   AST_BRD: assert property (brd_type_f || brd_type_a |-> protocol_mode == NOMC_M_BRD)
      else $error("detect enable bad");
   AST_ROLE: assert property (protocol_mode inside {NOMC_M_PT_A, NOMC_M_PT_F, NOMC_M_TG_AP,
      NOMC_M_BRD} |-> target_role)
      else $error("target role bad");
   AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   // a refused mode write must keep its error code until taken
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp changed");
endmodule // nomc_checker
bind nomc_top nomc_checker u_chk (.mclk(mclk), .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .osc_reg_enable(osc_reg_enable),
   .ready_mode(ready_mode), .rx_enable(rx_enable), .rx_am_active(rx_am_active),
   .rx_pm_active(rx_pm_active), .rx_auto_select(rx_auto_select), .tx_enable(tx_enable),
   .field_detector_mode(field_detector_mode), .low_power_nfc_mode(low_power_nfc_mode),
   .target_role(target_role), .protocol_mode(protocol_mode),
   .auto_response_field(auto_response_field), .auto_response_start(auto_response_start),
   .brd_type_f(brd_type_f), .brd_type_a(brd_type_a),
   .use_passive_target_drive(use_passive_target_drive));
`default_nettype wire

// [test_nfc_operation_mode_control.sv]
// test_nfc_operation_mode_control: register-level bench for nomc_top
// assumes nomc_regs.svh and nomc_pkg are compiled first; 250 MHz mclk
`timescale 1ns/100ps
`default_nettype none
`include "nomc_regs.svh"
module test_nfc_operation_mode_control;
   import nomc_pkg::*;
   localparam logic [7:0] A_OP = 8'(`NOMC_ADDR_OPCTL);
   localparam logic [7:0] A_MD = 8'(`NOMC_ADDR_MODEDEF);
   localparam logic [1:0] OK = `NOMC_RESP_OKAY;
   localparam logic [1:0] ERR = `NOMC_RESP_SLVERR;
   logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, xok, fon, txd, pick;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        osc, rdy, rxen, am, pm, asel, txen, wu, lp, targ, mam, ars, bf, ba, ptd;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, arf;
   nomc_fd_t    fd;
   nomc_mode_t  pmode;
   int          errors, num_checks;
   logic [7:0]  ops [10] = '{8'hC0, 8'hD0, 8'hE0, 8'hE0, 8'hCC, 8'h41, 8'h02, 8'h03, 8'h01, 8'h06};
   logic [9:0]  pks = 10'b0000001010;
   logic [4:0]  mcs [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h0E, 5'h0F, 5'h05,
                             5'h11, 5'h14, 5'h17, 5'h12, 5'h1C, 5'h19};
   nomc_mode_t  mex [14] = '{NOMC_M_AP2P, NOMC_M_TYPEA, NOMC_M_TYPEB, NOMC_M_TYPEF,
                             NOMC_M_T1T, NOMC_M_SUBC, NOMC_M_BPSK, NOMC_M_NONE, NOMC_M_PT_A,
                             NOMC_M_PT_F, NOMC_M_TG_AP, NOMC_M_NONE, NOMC_M_BRD, NOMC_M_BRD};
   nomc_top DUT (.mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .crystal_ok(xok), .field_on_cmd(fon), .active_tx_done(txd), .osc_reg_enable(osc),
      .ready_mode(rdy), .rx_enable(rxen), .rx_am_active(am), .rx_pm_active(pm),
      .rx_auto_select(asel), .tx_enable(txen), .wake_up_mode(wu), .field_detector_mode(fd),
      .low_power_nfc_mode(lp), .target_role(targ), .protocol_mode(pmode),
      .modulation_am(mam), .auto_response_field(arf), .auto_response_start(ars),
      .brd_type_f(bf), .brd_type_a(ba), .use_passive_target_drive(ptd),
      .receive_channel_pick(pick));
   // ==========================================================
   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #40000;
      errors++;
      summarize();
   end
   // ==========================================================
   // bus tasks; readies sampled mid-cycle
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                         input logic [1:0] er);
      logic       ta, tw, tb;
      logic [1:0] r;
      int         n;
      tb = 1'b0;
      n = 0;
      @(posedge mclk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      while (!tb && n < 50) begin
         @(negedge mclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         r = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      chk({29'h0, tb, r}, {29'h0, 1'b1, er}, "bresp");
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic        ta, tr;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      tr = 1'b0;
      n = 0;
      @(posedge mclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!tr && n < 50) begin
         @(negedge mclk);
         ta = arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      chk(d, {24'h0, ed}, "rdata");
      chk({29'h0, tr, r}, {29'h0, 1'b1, er}, "rresp");
   endtask
   // outputs trail registers by one stage plus synchronisers
   task automatic settle();
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic pulse(input logic done);
      @(posedge mclk);
      fon <= !done;
      txd <= done;
      repeat (3) @(posedge mclk);
      fon <= 1'b0;
      txd <= 1'b0;
      settle();
   endtask
   task automatic summarize();
      $display("errors=%0d checks=%0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [7:0]  v;
      logic [4:0]  c;
      logic [1:0]  ar;
      logic        p, sup, brd;
      {awvalid, wvalid, bready, arvalid, rready, fon, txd, pick, rst_b, xok} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      axi_rd(A_OP, 8'h00, OK);
      axi_rd(A_MD, 8'h08, OK);
      settle();
      chk(32'(pmode), 32'(NOMC_M_TYPEA), "reset mode");
      axi_wr(A_MD, 8'h80, 4'hF, ERR);
      axi_rd(A_MD, 8'h08, OK);
      xok <= 1'b1;
      // operation control bits under type A
      for (int i = 0; i < 10; i++) begin
         v = ops[i];
         p = pks[i];
         @(posedge mclk);
         pick <= p;
         axi_wr(A_OP, v, 4'hF, OK);
         axi_rd(A_OP, v, OK);
         settle();
         chk({osc, rdy, rxen, am, pm, asel, txen, wu, fd, lp},
             {v[7], v[7], v[6], v[6] & !(v[5] & p), v[6] & (!v[5] | p),
              v[6] & !v[5] & !v[4], v[3], v[2], v[1:0], (v[1:0] != 0) && (v[7:2] == 0)},
             "op outputs");
      end
      // fourteen mode codes, modulation and auto response varied
      axi_wr(A_OP, 8'hC8, 4'hF, OK);
      for (int i = 0; i < 14; i++) begin
         c = mcs[i];
         ar = 2'(i >> 1);
         v = {c, i[0], ar};
         sup = mex[i] != NOMC_M_NONE;
         brd = mex[i] == NOMC_M_BRD;
         axi_wr(A_MD, v, 4'hF, OK);
         axi_rd(A_MD, v, OK);
         settle();
         chk({targ, rxen, txen, mam, arf, ars, ptd, bf, ba, pmode},
             {c[4], sup, sup, i[0], ar, ar == 2'h1 || ar == 2'h2,
              mex[i] inside {NOMC_M_PT_A, NOMC_M_PT_F, NOMC_M_BRD}, brd & c[2], brd & c[0],
              mex[i]}, "mode outputs");
      end
      // hardware set and clear of transmit enable
      axi_wr(A_MD, 8'h08, 4'hF, OK);
      axi_wr(A_OP, 8'hC1, 4'hF, OK);
      pulse(1'b0);
      chk({31'h0, txen}, 32'h1, "tx set");
      axi_rd(A_OP, 8'hC9, OK);
      axi_wr(A_MD, 8'h00, 4'hF, OK);
      axi_wr(A_OP, 8'hCB, 4'hF, OK);
      pulse(1'b1);
      chk({31'h0, txen}, 32'h0, "tx clear");
      axi_rd(A_OP, 8'hC3, OK);
      // unmapped place and a write without its byte strobe
      axi_wr(8'h10, 8'hFF, 4'hF, ERR);
      axi_rd(8'h10, 8'h00, ERR);
      axi_wr(A_OP, 8'h00, 4'h0, OK);
      axi_rd(A_OP, 8'hC3, OK);
      summarize();
   end
endmodule // test_nfc_operation_mode_control
`default_nettype wire
